// file: hdl/osc_consts.svh
// Purpose: offsets, field positions, reset values and counts of the
//   oscillator control block.
// Assumes: included by bare name.
// Notes: definitions only.
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define CTRL_RESET 8'h00
`define CTRL_WRITE_MASK 8'haf
`define BIT_EXT_REF_ENABLE 7
`define BIT_STOP_KEEP 5
`define BIT_CAP_TWO 3
`define BIT_CAP_FOUR 2
`define BIT_CAP_EIGHT 1
`define BIT_CAP_SIXTEEN 0
`define STABLE_COUNT 13'h1000
`define PIN_RAW 0
`define PIN_EXT 1

`endif

// file: hdl/osc_pkg.sv
// Purpose: types shared by the oscillator control block.
// Assumes: nothing.
// Notes: none.
package osc_pkg;
  typedef enum logic [1:0] {
    osc_off = 2'b00,
    osc_startup = 2'b01,
    osc_stable = 2'b10,
    osc_external = 2'b11
  } osc_mode_type;
  typedef logic [12:0] stab_count_type;
endpackage

// file: hdl/stab_if.sv
// Purpose: link between the control logic and the stability counter.
// Assumes: one clock.
// Notes: tick is a one-cycle pulse per crystal rising edge.
`timescale 1ns/10ps
interface stab_if;
  logic run;
  logic tick;
  logic done;
  modport counter (input run, input tick, output done);
  modport control (output run, output tick, input done);
endinterface

// file: hdl/stability_counter.sv
// Purpose: counts crystal edges until the oscillator is deemed stable.
// Assumes: tick already synchronised to clock.
// Notes: done holds until run falls.
`timescale 1ns/10ps
`include "osc_consts.svh"
module stability_counter import osc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control side
  stab_if.counter link
);
  stab_count_type count;
  stab_count_type next_count;
  logic done;
  logic next_done;

  always_comb begin
    next_count = count;
    if (!link.run) begin
      next_count = 13'h0000;
    end else if (link.tick && !done) begin
      next_count = count + 13'h0001;
    end
    next_done = link.run && (next_count == `STABLE_COUNT);
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      count <= 13'h0000;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end

  assign link.done = done;

  count_clear_a: assert property (@(posedge clock)
    disable iff (!resetn)
    !link.run |=> (count == 13'h0000) && !link.done)
    else $error("stability count not cleared while idle");

  done_needs_count_a: assert property (@(posedge clock)
    disable iff (!resetn)
    $rose(link.done) |-> $past(count) == 13'h0fff && $past(link.tick))
    else $error("stable flagged before the full count");
endmodule

// file: hdl/clock_gate.sv
// Purpose: glitch-free gate for one oscillator-derived clock.
// Assumes: src is a sampled clock level on the same clock.
// Notes: the enable is only taken while src is low, so a pulse is
//   never cut short nor a runt created.
`timescale 1ns/10ps
module clock_gate (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Source and control
  input wire logic src,
  input wire logic enable,
  // Gated output
  output logic gated
);
  logic en_q;
  logic next_en_q;
  logic next_gated;

  always_comb begin
    next_en_q = src ? en_q : enable;
    next_gated = src && en_q;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      en_q <= 1'b0;
      gated <= 1'b0;
    end else begin
      en_q <= next_en_q;
      gated <= next_gated;
    end
  end

  enable_low_only_a: assert property (@(posedge clock)
    disable iff (!resetn)
    $changed(en_q) |-> !$past(src))
    else $error("gate enable changed while source high");
endmodule

// file: hdl/crystal_osc_clock_gating.sv
// Purpose: digital control of a crystal oscillator: control register,
//   stability count, bypass and gating of three derived clocks.
// Assumes: 100 MHz clock well above the crystal or bypass clock;
//   chip mode inputs come from logic on the same clock.
// Notes: the derived clocks are sampled copies, so their edges move
//   on the 10 ns grid.
// Operation
// - Peripheral reference clock runs only while its enable bit is set.
// - Stop-keep bit holds peripheral clock in stop if enabled on entry.
// - Control bits 6 and 4 read zero and ignore writes.
// - Bits 3 and 2 select the 2 pF and 4 pF load capacitors.
// - Bits 1 and 0 select the 8 pF and 16 pF load capacitors.
// - One 8-bit read/write control register, zero after reset.
// - Three clock outputs: system, peripheral and low frequency.
// - System oscillator clock runs only in run mode.
// - Peripheral and low-frequency clocks may run in low-power modes.
// - External clock on the input pin may bypass the oscillator.
// - Oscillator output stays off until 4096 crystal cycles are seen.
// - Stability count clears whenever the oscillator is not enabled.
// - Enabled without internal select forwards the input pin clock.
// - Wake-up from very-low-leakage stop resets every register bit.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
`include "osc_consts.svh"
module crystal_osc_clock_gating import osc_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [3:0] address,
  input wire logic [7:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [7:0] read_data,
  // Chip power and clock-generator control
  input wire logic osc_enable,
  input wire logic internal_osc_select,
  input wire logic run_mode,
  input wire logic stop_mode,
  input wire logic vlls_wakeup,
  // Pins and analog core
  input wire logic clock_input_pin,
  input wire logic raw_crystal_clock,
  output logic amplifier_enable,
  output logic load_cap_two_pf,
  output logic load_cap_four_pf,
  output logic load_cap_eight_pf,
  output logic load_cap_sixteen_pf,
  // Derived clocks
  output logic system_osc_clock,
  output logic peripheral_ref_clock,
  output logic low_freq_ref_clock
);
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_read_data;
  logic kept_in_stop;
  logic next_kept_in_stop;
  logic next_amplifier_enable;
  osc_mode_type mode;
  logic osc_src;
  logic next_osc_src;
  logic raw_prev;
  logic [1:0] pin_in;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] sync3;
  logic [1:0] pin_level;
  logic [2:0] gate_enable;
  logic [2:0] gate_out;
  logic sys_on;
  logic periph_on;
  logic lf_on;
  stab_if stab ();

  // Pin synchronisers: a change counts once stages two and three agree
  assign pin_in[`PIN_RAW] = raw_crystal_clock;
  assign pin_in[`PIN_EXT] = clock_input_pin;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_sync
      logic next_level;
      always_comb begin
        next_level = (sync2[g] == sync3[g]) ? sync3[g] : pin_level[g];
      end
      always_ff @(posedge clock) begin
        if (!resetn) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin_level[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          pin_level[g] <= next_level;
        end
      end
    end
  endgenerate

  // Control register and read port
  always_comb begin
    next_ctrl = ctrl;
    if (vlls_wakeup) begin
      next_ctrl = `CTRL_RESET;
    end else if (write_strobe && address == `CTRL_OFFSET) begin
      next_ctrl = write_data & `CTRL_WRITE_MASK;
    end
    next_read_data = 8'h00;
    if (read_strobe) begin
      unique case (address)
        `CTRL_OFFSET: next_read_data = ctrl;
        `STATUS_OFFSET: next_read_data = {5'h00, stab.done, mode};
        default: next_read_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      ctrl <= `CTRL_RESET;
      read_data <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
      read_data <= next_read_data;
    end
  end

  assign load_cap_two_pf = ctrl[`BIT_CAP_TWO];
  assign load_cap_four_pf = ctrl[`BIT_CAP_FOUR];
  assign load_cap_eight_pf = ctrl[`BIT_CAP_EIGHT];
  assign load_cap_sixteen_pf = ctrl[`BIT_CAP_SIXTEEN];

  // Oscillator mode and qualified source clock
  always_comb begin
    if (!osc_enable) begin
      mode = osc_off;
    end else if (!internal_osc_select) begin
      mode = osc_external;
    end else if (stab.done) begin
      mode = osc_stable;
    end else begin
      mode = osc_startup;
    end
  end

  assign stab.run = osc_enable && internal_osc_select;
  assign stab.tick = pin_level[`PIN_RAW] && !raw_prev;

  always_comb begin
    unique case (mode)
      osc_off: next_osc_src = 1'b0;
      osc_startup: next_osc_src = 1'b0;
      osc_stable: next_osc_src = pin_level[`PIN_RAW];
      osc_external: next_osc_src = pin_level[`PIN_EXT];
    endcase
    next_amplifier_enable = osc_enable && internal_osc_select;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      osc_src <= 1'b0;
      raw_prev <= 1'b0;
      amplifier_enable <= 1'b0;
    end else begin
      osc_src <= next_osc_src;
      raw_prev <= pin_level[`PIN_RAW];
      amplifier_enable <= next_amplifier_enable;
    end
  end

  stability_counter u_counter (
    .clock(clock),
    .resetn(resetn),
    .link(stab.counter)
  );

  // Stop-mode keep is frozen on entry, so a late write cannot revive it.
  // Taken from the value being written, so a write just before entry counts
  always_comb begin
    next_kept_in_stop = kept_in_stop;
    if (vlls_wakeup) begin
      next_kept_in_stop = 1'b0;
    end else if (!stop_mode) begin
      next_kept_in_stop = next_ctrl[`BIT_EXT_REF_ENABLE] &&
                          next_ctrl[`BIT_STOP_KEEP];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      kept_in_stop <= 1'b0;
    end else begin
      kept_in_stop <= next_kept_in_stop;
    end
  end

  assign sys_on = osc_enable && run_mode && !stop_mode;
  assign periph_on = ctrl[`BIT_EXT_REF_ENABLE] &&
                     (!stop_mode || kept_in_stop);
  assign lf_on = osc_enable;
  assign gate_enable = {lf_on, periph_on, sys_on};

  generate
    for (g = 0; g < 3; g++) begin : gen_gate
      clock_gate u_gate (
        .clock(clock),
        .resetn(resetn),
        .src(osc_src),
        .enable(gate_enable[g]),
        .gated(gate_out[g])
      );
    end
  endgenerate

  assign system_osc_clock = gate_out[0];
  assign peripheral_ref_clock = gate_out[1];
  assign low_freq_ref_clock = gate_out[2];

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);

  periph_enable_a: assert property (
    $rose(peripheral_ref_clock) |-> $past(periph_on, 2) &&
      $past(ctrl[`BIT_EXT_REF_ENABLE], 2))
    else $error("peripheral clock rose without enable");

  stop_keep_a: assert property (
    $rose(peripheral_ref_clock) && $past(stop_mode, 2) |->
      $past(kept_in_stop, 2))
    else $error("peripheral clock started in stop without keep");

  reserved_zero_a: assert property (
    read_strobe |=> !read_data[6] && !read_data[4])
    else $error("reserved control bits read nonzero");

  small_caps_a: assert property (
    write_strobe && address == `CTRL_OFFSET && !vlls_wakeup |=>
      load_cap_two_pf == $past(write_data[3]) &&
      load_cap_four_pf == $past(write_data[2]))
    else $error("2 pF or 4 pF select not following write");

  large_caps_a: assert property (
    write_strobe && address == `CTRL_OFFSET && !vlls_wakeup |=>
      load_cap_eight_pf == $past(write_data[1]) &&
      load_cap_sixteen_pf == $past(write_data[0]))
    else $error("8 pF or 16 pF select not following write");

  ctrl_reset_a: assert property (
    !$past(resetn) |-> ctrl == 8'h00 && read_data == 8'h00)
    else $error("control register not zero after reset");

  sys_run_only_a: assert property (
    $rose(system_osc_clock) |-> $past(run_mode, 2) &&
      !$past(stop_mode, 2))
    else $error("system clock started outside run mode");

  low_freq_a: assert property (
    $rose(low_freq_ref_clock) |-> $past(osc_enable, 2))
    else $error("low-frequency clock started while disabled");

  startup_gated_a: assert property (
    osc_enable && internal_osc_select && !stab.done |=> !osc_src)
    else $error("oscillator clock passed before stable");

  bypass_pass_a: assert property (
    osc_enable && !internal_osc_select |=>
      osc_src == $past(pin_level[`PIN_EXT]))
    else $error("bypass clock not forwarded");

  wake_reset_a: assert property (
    vlls_wakeup |=> ctrl == 8'h00 && !kept_in_stop)
    else $error("wake-up did not clear control register");

  amp_off_bypass_a: assert property (
    osc_enable && !internal_osc_select |=> !amplifier_enable)
    else $error("amplifier enabled in external clock mode");

  other_addr_a: assert property (
    write_strobe && address != `CTRL_OFFSET && !vlls_wakeup |=>
      $stable(ctrl))
    else $error("write to another address changed control");

  status_done_a: assert property (
    read_strobe && address == `STATUS_OFFSET |=>
      read_data[2] == $past(stab.done))
    else $error("status stable flag wrong");

  gate_follow_a: assert property (
    peripheral_ref_clock || system_osc_clock || low_freq_ref_clock |->
      $past(osc_src))
    else $error("gated clock high without source");

  bypass_cover_c: cover property (
    osc_enable && !internal_osc_select ##1 $rose(osc_src));
  stable_cover_c: cover property ($rose(stab.done));
  stop_keep_cover_c: cover property (
    stop_mode && kept_in_stop && $rose(peripheral_ref_clock));
  sys_run_cover_c: cover property (run_mode && $rose(system_osc_clock));
endmodule

// file: tb/amplifier_output_pin_source.sv
// Purpose: crystal and bypass clock source at the oscillator pins.
// Assumes: the crystal only swings while the amplifier is enabled.
// Notes: both clocks rest low when off, so no stale edge can leak in.
`timescale 1ns/10ps
module amplifier_output_pin_source #(
  parameter int half_ns = 40
) (
  // Control
  input wire logic amplifier_enable,
  input wire logic ext_on,
  // Pins
  output logic raw_crystal_clock,
  output logic clock_input_pin
);
  initial begin
    raw_crystal_clock = 1'b0;
    clock_input_pin = 1'b0;
    #3;
    forever begin
      #(half_ns);
      raw_crystal_clock <= amplifier_enable ? ~raw_crystal_clock : 1'b0;
      clock_input_pin <= ext_on ? ~clock_input_pin : 1'b0;
    end
  end
endmodule

// file: tb/testbench.sv
// Purpose: self-checking bench of the oscillator control block.
// Assumes: crystal period 80 ns, so one crystal cycle is 8 clocks.
// Notes: clock activity is judged by counting rising edges in a window.
`timescale 1ns/10ps
`include "osc_consts.svh"
module testbench;
  import osc_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] address = 4'h0;
  logic [7:0] write_data = 8'h00;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [7:0] read_data;
  logic osc_enable = 1'b0;
  logic internal_osc_select = 1'b0;
  logic run_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic vlls_wakeup = 1'b0;
  logic ext_on = 1'b0;
  logic clock_input_pin, raw_crystal_clock, amplifier_enable;
  logic load_cap_two_pf, load_cap_four_pf;
  logic load_cap_eight_pf, load_cap_sixteen_pf;
  logic system_osc_clock, peripheral_ref_clock, low_freq_ref_clock;
  logic [2:0] prev = 3'b000;
  int rises [3] = '{0, 0, 0};
  int mismatches = 0;
  int checked = 0;
  logic [7:0] got;
  // Rows: value written, value read back, load-cap outputs {2,4,8,16}
  logic [7:0] rows [7][3] = '{'{8'hff, 8'haf, 8'h0f},
    '{8'h50, 8'h00, 8'h00}, '{8'h08, 8'h08, 8'h08},
    '{8'h04, 8'h04, 8'h04}, '{8'h02, 8'h02, 8'h02},
    '{8'h01, 8'h01, 8'h01}, '{8'ha0, 8'ha0, 8'h00}};

  always #5 clock = ~clock;

  crystal_osc_clock_gating dut_u (
    .clock(clock), .resetn(resetn), .address(address),
    .write_data(write_data), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .read_data(read_data),
    .osc_enable(osc_enable), .internal_osc_select(internal_osc_select),
    .run_mode(run_mode), .stop_mode(stop_mode),
    .vlls_wakeup(vlls_wakeup), .clock_input_pin(clock_input_pin),
    .raw_crystal_clock(raw_crystal_clock),
    .amplifier_enable(amplifier_enable),
    .load_cap_two_pf(load_cap_two_pf), .load_cap_four_pf(load_cap_four_pf),
    .load_cap_eight_pf(load_cap_eight_pf),
    .load_cap_sixteen_pf(load_cap_sixteen_pf),
    .system_osc_clock(system_osc_clock),
    .peripheral_ref_clock(peripheral_ref_clock),
    .low_freq_ref_clock(low_freq_ref_clock)
  );

  amplifier_output_pin_source source_u (
    .amplifier_enable(amplifier_enable), .ext_on(ext_on),
    .raw_crystal_clock(raw_crystal_clock),
    .clock_input_pin(clock_input_pin)
  );

  always @(posedge clock) begin
    prev <= {system_osc_clock, peripheral_ref_clock, low_freq_ref_clock};
    if (system_osc_clock === 1'b1 && !prev[2]) rises[0] <= rises[0] + 1;
    if (peripheral_ref_clock === 1'b1 && !prev[1]) rises[1] <= rises[1] + 1;
    if (low_freq_ref_clock === 1'b1 && !prev[0]) rises[2] <= rises[2] + 1;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    checked++;
    if (seen !== expected) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask

  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(posedge clock);
    d = read_data;
  endtask

  // Settle, then note which derived clocks toggle within n cycles
  task automatic watch(input int n, input logic [2:0] expected);
    int base [3];
    repeat (12) @(posedge clock);
    base = rises;
    repeat (n) @(posedge clock);
    check({5'h00, rises[0] != base[0], rises[1] != base[1],
      rises[2] != base[2]}, {5'h00, expected});
  endtask

  task automatic results();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    results();
  end

  initial begin
    repeat (10) @(posedge clock);
    check(read_data, 8'h00);
    resetn <= 1'b1;
    read_reg(`CTRL_OFFSET, got);
    check(got, 8'h00);
    foreach (rows[i]) begin
      write_reg(`CTRL_OFFSET, rows[i][0]);
      read_reg(`CTRL_OFFSET, got);
      check(got, rows[i][1]);
      check({4'h0, load_cap_two_pf, load_cap_four_pf, load_cap_eight_pf,
        load_cap_sixteen_pf}, rows[i][2]);
    end
    read_reg(4'h8, got);
    check(got, 8'h00);
    write_reg(`STATUS_OFFSET, 8'hff);
    read_reg(`CTRL_OFFSET, got);
    check(got, 8'ha0);
    // Wake from deep stop wipes the register
    write_reg(`CTRL_OFFSET, 8'haf);
    @(posedge clock);
    vlls_wakeup <= 1'b1;
    @(posedge clock);
    vlls_wakeup <= 1'b0;
    read_reg(`CTRL_OFFSET, got);
    check(got, 8'h00);
    // Bypass: pin clock reaches the outputs with no stability count
    write_reg(`CTRL_OFFSET, 8'h80);
    run_mode <= 1'b1;
    ext_on <= 1'b1;
    osc_enable <= 1'b1;
    watch(40, 3'b111);
    check({7'h00, amplifier_enable}, 8'h00);
    read_reg(`STATUS_OFFSET, got);
    check(got, 8'h03);
    osc_enable <= 1'b0;
    ext_on <= 1'b0;
    watch(40, 3'b000);
    // Crystal start-up: quiet until 4096 crystal cycles
    internal_osc_select <= 1'b1;
    osc_enable <= 1'b1;
    read_reg(`STATUS_OFFSET, got);
    check(got, 8'h01);
    watch(4000 * 8, 3'b000);
    watch(200 * 8, 3'b111);
    check({7'h00, amplifier_enable}, 8'h01);
    read_reg(`STATUS_OFFSET, got);
    check(got, 8'h06);
    run_mode <= 1'b0;
    watch(40, 3'b011);
    run_mode <= 1'b1;
    write_reg(`CTRL_OFFSET, 8'h00);
    watch(40, 3'b101);
    write_reg(`CTRL_OFFSET, 8'h80);
    stop_mode <= 1'b1;
    watch(40, 3'b001);
    stop_mode <= 1'b0;
    write_reg(`CTRL_OFFSET, 8'ha0);
    stop_mode <= 1'b1;
    watch(40, 3'b011);
    stop_mode <= 1'b0;
    // Enabling only inside stop must not revive the clock
    write_reg(`CTRL_OFFSET, 8'h20);
    stop_mode <= 1'b1;
    write_reg(`CTRL_OFFSET, 8'ha0);
    watch(40, 3'b001);
    stop_mode <= 1'b0;
    // A restart clears the count, so the outputs stay quiet for 2000 crystal cycles
    osc_enable <= 1'b0;
    repeat (20) @(posedge clock);
    osc_enable <= 1'b1;
    watch(2000 * 8, 3'b000);
    // Reset in mid-run returns the register and load selects to zero
    osc_enable <= 1'b0;
    write_reg(`CTRL_OFFSET, 8'h8f);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    check({4'h0, load_cap_two_pf, load_cap_four_pf, load_cap_eight_pf,
      load_cap_sixteen_pf}, 8'h00);
    read_reg(`CTRL_OFFSET, got);
    check(got, 8'h00);
    results();
  end
endmodule
